// [rtl/dsr_adapter.sv]
`timescale 1ns/1ps
`include "dsr_params.svh"
module dsr_fifo #(
	parameter int W     = `DSR_WORD_W,
	parameter int DEPTH = `DSR_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic         hclk,
	input  wire logic         hresetn,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem_q [DEPTH];
	logic [AW:0]  wp_q;
	logic [AW:0]  rp_q;

	assign in_ready  = !((wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]));
	assign out_valid = (wp_q != rp_q);
	assign out_data  = mem_q[rp_q[AW-1:0]];

	always_ff @(posedge hclk) begin
		if (in_valid && in_ready) begin
			mem_q[wp_q[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wp_q <= '0;
		end else if (in_valid && in_ready) begin
			wp_q <= wp_q + (AW+1)'(1);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rp_q <= '0;
		end else if (out_valid && out_ready) begin
			rp_q <= rp_q + (AW+1)'(1);
		end
	end
endmodule // dsr_fifo

module dsr_adapter
	import dsr_pkg::*;
(
	// Clock and reset
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	// Multiplexed digit link
	dsr_link_if.adapter                link,
	// Reordered strobes and code
	output logic [3:0]                 ord_strobe,
	output logic [3:0]                 ord_code,
	// Digit stream
	output logic                       m_valid,
	input  wire logic                  m_ready,
	output logic [`DSR_WORD_W-1:0]     m_data,
	// Stream lost a digit
	output logic                       overrun
);
	logic [3:0]  sel;
	logic [3:0]  pass;
	logic        msd_prev_q;
	logic        pair_q;
	logic [3:0]  ord_strobe_q;
	logic [3:0]  ord_code_q;
	logic        pend_q;
	dsr_word_t   pend_word_q;
	logic        overrun_q;
	logic        fifo_ready;
	logic        start;
	logic [3:0]  code_m;
	dsr_word_t   word_d;

	assign sel = {link.msd_strobe, link.third_digit_strobe, link.second_digit_strobe, link.lsd_strobe};

	// Pair 0 passes digits 1,2; pair 1 passes 3,4
	assign pass   = sel & (pair_q ? 4'b1100 : 4'b0011);
	assign code_m = sel[3] ? (link.digit_code & `DSR_MSD_MASK) : link.digit_code;
	assign start  = (pass != 4'h0) && (ord_strobe_q == 4'h0);

	always_comb begin
		word_d.code = code_m;
		word_d.idx  = 2'd0;
		for (int i = 0; i < 4; i++) begin
			if (pass[i]) begin
				word_d.idx = 2'(i);
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			msd_prev_q <= 1'b0;
			pair_q     <= 1'b0;
		end else begin
			msd_prev_q <= link.msd_strobe;
			if (msd_prev_q && !link.msd_strobe) begin
				pair_q <= !pair_q;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ord_strobe_q <= 4'h0;
			ord_code_q   <= 4'h0;
		end else begin
			ord_strobe_q <= pass;
			ord_code_q   <= (pass != 4'h0) ? code_m : 4'h0;
		end
	end

	// One digit held until the FIFO takes it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_q      <= 1'b0;
			pend_word_q <= '0;
		end else if (start && (!pend_q || fifo_ready)) begin
			pend_q      <= 1'b1;
			pend_word_q <= word_d;
		end else if (pend_q && fifo_ready) begin
			pend_q <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			overrun_q <= 1'b0;
		end else begin
			overrun_q <= start && pend_q && !fifo_ready;
		end
	end

	dsr_fifo #(
		.W     (`DSR_WORD_W),
		.DEPTH (`DSR_FIFO_DEPTH)
	) u_fifo (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.in_valid  (pend_q),
		.in_ready  (fifo_ready),
		.in_data   (pend_word_q),
		.out_valid (m_valid),
		.out_ready (m_ready),
		.out_data  (m_data)
	);

	assign ord_strobe = ord_strobe_q;
	assign ord_code   = ord_code_q;
	assign overrun    = overrun_q;
endmodule // dsr_adapter

// [rtl/dsr_link_if.sv]
`timescale 1ns/1ps
interface dsr_link_if;
	logic [3:0] digit_code;
	logic       msd_strobe;
	logic       second_digit_strobe;
	logic       third_digit_strobe;
	logic       lsd_strobe;
	logic       eoc_n;

	modport meter (
		output digit_code,
		output msd_strobe,
		output second_digit_strobe,
		output third_digit_strobe,
		output lsd_strobe,
		output eoc_n
	);

	modport adapter (
		input digit_code,
		input msd_strobe,
		input second_digit_strobe,
		input third_digit_strobe,
		input lsd_strobe,
		input eoc_n
	);
endinterface

// [rtl/dsr_meter.sv]
// Behaviour
// - Digits numbered 1-4, right to left
// - Scan order 1,3,2,4, repeated forever
// - Code and digit strobes are active high
// - End-of-conversion strobe is active low
// - One strobe about 0.4 ms, one slot
// - Full native scan about 1.56 ms
// - Adapter passes digits 1,2 then 3,4
// - Pair toggle on msd strobe falling edge
// - Adapter presents strobes in order 1,2,3,4
// - Reordered sequence spans two scans, 3.12 ms
// - Internal count reaches about 3100
// - Display blinks from count 2000 upward
// - Adapter forces msd code bits 4,8 low
// - Four separate digit select strobes
//
// The AHB-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "dsr_params.svh"
module dsr_meter
	import dsr_pkg::*;
(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	// Multiplexed digit link
	dsr_link_if.meter        link
);

	dsr_slot_t              slot_q;
	logic [`DSR_CNT_W-1:0]  cnt_q;
	logic                   run_q;
	logic [`DSR_CNT_W-1:0]  count_q;
	logic [`DSR_CNT_W-1:0]  shown_q;
	logic [5:0]             scan_q;
	logic                   wr_pend_q;
	logic [7:0]             wr_addr_q;
	logic [31:0]            rdata_q;
	logic [3:0]             code_q;
	logic [3:0]             sel_q;
	logic                   eoc_n_q;
	logic                   slot_end;
	logic                   strobe_on;
	logic                   over;
	logic                   blank;
	logic                   addr_take;
	logic [3:0]             d_ones;
	logic [3:0]             d_tens;
	logic [3:0]             d_hund;
	logic [1:0]             d_thou;
	logic [3:0]             code_d;
	logic [3:0]             sel_d;
	logic [`DSR_CNT_W-1:0]  wcount;
	logic [31:0]            rdata_d;

	// Slot timing
	assign slot_end  = (cnt_q == `DSR_CNT_W'(`DSR_SLOT_CYC - 1));
	assign strobe_on = run_q && (cnt_q < `DSR_CNT_W'(`DSR_STROBE_CYC));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= '0;
		end else if (!run_q || slot_end) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + `DSR_CNT_W'(1);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			slot_q <= DSR_SLOT_LSD;
		end else if (!run_q) begin
			slot_q <= DSR_SLOT_LSD;
		end else if (slot_end) begin
			unique case (slot_q)
				DSR_SLOT_LSD:    slot_q <= DSR_SLOT_THIRD;
				DSR_SLOT_THIRD:  slot_q <= DSR_SLOT_SECOND;
				DSR_SLOT_SECOND: slot_q <= DSR_SLOT_MSD;
				DSR_SLOT_MSD:    slot_q <= DSR_SLOT_LSD;
			endcase
		end
	end

	// Scan counter drives the blink phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scan_q <= '0;
		end else if (run_q && slot_end && slot_q == DSR_SLOT_MSD) begin
			scan_q <= scan_q + 6'h01;
		end
	end

	// Reading is frozen for a whole scan
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shown_q <= `DSR_COUNT_RESET;
		end else if (!run_q || (slot_end && slot_q == DSR_SLOT_MSD)) begin
			shown_q <= count_q;
		end
	end

	// Decimal digits of the frozen reading
	assign d_ones = 4'(shown_q % 10);
	assign d_tens = 4'((shown_q / 10) % 10);
	assign d_hund = 4'((shown_q / 100) % 10);
	assign d_thou = 2'(shown_q / 1000);
	assign over   = shown_q >= `DSR_CNT_W'(`DSR_OVR_COUNT);
	assign blank  = over && scan_q[`DSR_BLINK_BIT];

	// Blanked msd drives its upper code bits high
	always_comb begin
		code_d = 4'h0;
		sel_d  = 4'h0;
		if (strobe_on) begin
			unique case (slot_q)
				DSR_SLOT_LSD: begin
					code_d = d_ones;
					sel_d  = 4'b0001;
				end
				DSR_SLOT_SECOND: begin
					code_d = d_tens;
					sel_d  = 4'b0010;
				end
				DSR_SLOT_THIRD: begin
					code_d = d_hund;
					sel_d  = 4'b0100;
				end
				DSR_SLOT_MSD: begin
					code_d = blank ? {2'b11, d_thou} : {2'b00, d_thou};
					sel_d  = 4'b1000;
				end
			endcase
		end
	end

	// Registered link outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			code_q  <= 4'h0;
			sel_q   <= 4'h0;
			eoc_n_q <= 1'b1;
		end else begin
			code_q  <= code_d;
			sel_q   <= sel_d;
			eoc_n_q <= !(run_q && !strobe_on && slot_q == DSR_SLOT_MSD);
		end
	end

	assign link.digit_code          = code_q;
	assign link.lsd_strobe          = sel_q[0];
	assign link.second_digit_strobe = sel_q[1];
	assign link.third_digit_strobe  = sel_q[2];
	assign link.msd_strobe          = sel_q[3];
	assign link.eoc_n               = eoc_n_q;

	// AHB-Lite slave, zero wait states
	assign addr_take = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else if (hready) begin
			wr_pend_q <= addr_take && hwrite;
			wr_addr_q <= haddr[7:0];
		end
	end

	always_comb begin
		rdata_d = 32'h0000_0000;
		unique case (haddr[7:0])
			`DSR_OFS_CTRL: rdata_d[`DSR_CTRL_RUN] = run_q;
			`DSR_OFS_COUNT: rdata_d[`DSR_CNT_W-1:0] = count_q;
			`DSR_OFS_STATUS: begin
				rdata_d[`DSR_ST_OVER]                    = over;
				rdata_d[`DSR_ST_BLANK]                   = blank;
				rdata_d[`DSR_ST_SLOT_HI:`DSR_ST_SLOT_LO] = slot_q;
				rdata_d[`DSR_ST_RUN]                     = run_q;
			end
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_q <= 32'h0000_0000;
		end else if (addr_take && !hwrite) begin
			rdata_q <= rdata_d;
		end
	end

	// Count saturates at the top of the range
	assign wcount = (hwdata[31:`DSR_CNT_W] != '0 || hwdata[`DSR_CNT_W-1:0] > `DSR_CNT_W'(`DSR_MAX_COUNT)) ?
		`DSR_CNT_W'(`DSR_MAX_COUNT) : hwdata[`DSR_CNT_W-1:0];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_q <= 1'(`DSR_CTRL_RESET);
		end else if (wr_pend_q && wr_addr_q == `DSR_OFS_CTRL) begin
			run_q <= hwdata[`DSR_CTRL_RUN];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_q <= `DSR_COUNT_RESET;
		end else if (wr_pend_q && wr_addr_q == `DSR_OFS_COUNT) begin
			count_q <= wcount;
		end
	end

endmodule // dsr_meter

// [rtl/dsr_params.svh]
`ifndef DSR_PARAMS_SVH
`define DSR_PARAMS_SVH

// Clock and scan timing
`define DSR_CLK_MHZ       10
`define DSR_SCAN_US       1560
`define DSR_STROBE_US     400
`define DSR_SLOTS         4
`define DSR_SLOT_CYC      (`DSR_SCAN_US * `DSR_CLK_MHZ / `DSR_SLOTS)
`define DSR_GAP_CYC       100
`define DSR_STROBE_CYC    (((`DSR_STROBE_US * `DSR_CLK_MHZ) < (`DSR_SLOT_CYC - `DSR_GAP_CYC)) ? \
                           (`DSR_STROBE_US * `DSR_CLK_MHZ) : (`DSR_SLOT_CYC - `DSR_GAP_CYC))
`define DSR_CNT_W         12

// Count range
`define DSR_MAX_COUNT     3100
`define DSR_OVR_COUNT     2000
`define DSR_BLINK_BIT     1

// Register map
`define DSR_OFS_CTRL      8'h00
`define DSR_OFS_COUNT     8'h04
`define DSR_OFS_STATUS    8'h08
`define DSR_CTRL_RUN      0
`define DSR_CTRL_RESET    32'h0000_0001
`define DSR_COUNT_RESET   12'h000
`define DSR_ST_OVER       0
`define DSR_ST_BLANK      1
`define DSR_ST_SLOT_LO    2
`define DSR_ST_SLOT_HI    3
`define DSR_ST_RUN        4

// Output stream
`define DSR_FIFO_DEPTH    8
`define DSR_WORD_W        6
`define DSR_MSD_MASK      4'h3

`endif

// [rtl/dsr_pkg.sv]
package dsr_pkg;

	// Native scan order, Gray coded along 1-3-2-4
	typedef enum logic [1:0] {
		DSR_SLOT_LSD   = 2'b00,
		DSR_SLOT_THIRD = 2'b01,
		DSR_SLOT_SECOND = 2'b11,
		DSR_SLOT_MSD   = 2'b10
	} dsr_slot_t;

	// Digit index 0 = lsd .. 3 = msd, then its code
	typedef struct packed {
		logic [1:0] idx;
		logic [3:0] code;
	} dsr_word_t;

endpackage

// [verification/digit_scan_reorder_adapter_bench.sv]
`timescale 1ns/1ps
`include "dsr_params.svh"
module digit_scan_reorder_adapter_bench;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, m_ready, m_valid, overrun, pair_q, eoc_p, blk;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans, exp_idx;
	logic [2:0]  hsize;
	logic [3:0]  ord_strobe, ord_code, sv_p, cd_p, msk;
	logic [3:0]  link_code [4];
	logic [3:0]  last_code [4];
	logic [5:0]  m_data;
	int          errors, total_checks, seed, v, scans;
	dsr_link_if link ();
	dsr_meter i_dsr_meter (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .link(link));
	dsr_adapter i_dsr_adapter (.hclk(hclk), .hresetn(hresetn), .link(link), .ord_strobe(ord_strobe),
		.ord_code(ord_code), .m_valid(m_valid), .m_ready(m_ready), .m_data(m_data), .overrun(overrun));
	dsr_link_properties i_dsr_link_properties (.hclk(hclk), .hresetn(hresetn),
		.digit_code(link.digit_code), .msd_strobe(link.msd_strobe), .lsd_strobe(link.lsd_strobe),
		.second_digit_strobe(link.second_digit_strobe), .third_digit_strobe(link.third_digit_strobe),
		.eoc_n(link.eoc_n));
	function automatic logic [3:0] digit(input int n, input int i);
		digit = 4'((n / (10 ** i)) % 10);
	endfunction
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		haddr <= {24'h000000, a};
		hwrite <= wr;
		htrans <= 2'b10;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'h0, 32'(hresp));
	endtask
	task automatic end_of_test();
		$display("Checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	always @(posedge hclk) m_ready <= 1'($random(seed));
	// Model of the pair toggle, compared mid-cycle
	always @(negedge hclk) begin
		if (hresetn !== 1'b1) begin
			pair_q = 1'b0;
			exp_idx = 2'd0;
			scans = 0;
		end else begin
			// Scans completed since reset, one per end-of-conversion rise
			if (!eoc_p && link.eoc_n)
				scans++;
			msk = sv_p & (pair_q ? 4'hc : 4'h3);
			chk("ord_strobe", 32'(msk), 32'(ord_strobe));
			chk("ord_code", 32'(msk == 4'h0 ? 4'h0 : (msk[3] ? cd_p & 4'h3 : cd_p)), 32'(ord_code));
			chk("overrun", 32'h0, 32'(overrun));
			if (sv_p[3] && !link.msd_strobe)
				pair_q = ~pair_q;
			for (int i = 0; i < 4; i++)
				if (ord_strobe[i])
					last_code[i] = ord_code;
			if (m_valid && m_ready) begin
				chk("m_idx", 32'(exp_idx), 32'(m_data[5:4]));
				chk("m_code", 32'(last_code[exp_idx]), 32'(m_data[3:0]));
				exp_idx = exp_idx + 2'd1;
			end
		end
		sv_p = {link.msd_strobe, link.third_digit_strobe, link.second_digit_strobe, link.lsd_strobe};
		cd_p = link.digit_code;
		eoc_p = link.eoc_n;
		for (int i = 0; i < 4; i++)
			if (sv_p[i])
				link_code[i] = cd_p;
	end
	initial begin
		#9_000_000;
		errors++;
		$display("Watchdog expired");
		end_of_test();
	end
	initial begin
		hresetn = 1'b0;
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		m_ready = 1'b0;
		sv_p = 4'h0;
		cd_p = 4'h0;
		errors = 0;
		total_checks = 0;
		seed = 50;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, `DSR_OFS_CTRL, 32'h0);
		chk("ctrl", `DSR_CTRL_RESET, rd);
		bus(1'b0, `DSR_OFS_COUNT, 32'h0);
		chk("count", 32'h0, rd);
		bus(1'b1, 8'h0c, 32'h0000_00a5);
		bus(1'b0, 8'h0c, 32'h0);
		chk("unmapped", 32'h0, rd);
		$display("Test registers done");
		for (int t = 0; t < 2; t++) begin
			v = t == 0 ? $unsigned($random(seed)) % 2000 : 4095;
			bus(1'b1, `DSR_OFS_COUNT, 32'(v));
			if (v > `DSR_MAX_COUNT)
				v = `DSR_MAX_COUNT;
			bus(1'b0, `DSR_OFS_COUNT, 32'h0);
			chk("count", 32'(v), rd);
			// Latch at one scan end, capture over the next
			@(posedge link.eoc_n);
			@(posedge link.eoc_n);
			// Blinking scans show the msd upper code bits high
			blk = v >= `DSR_OVR_COUNT && scans[`DSR_BLINK_BIT];
			for (int i = 0; i < 4; i++)
				chk("digit_code", 32'(digit(v, i) | (i == 3 && blk ? 4'hc : 4'h0)), 32'(link_code[i]));
			bus(1'b0, `DSR_OFS_STATUS, 32'h0);
			chk("over", 32'(v >= `DSR_OVR_COUNT), 32'(rd[`DSR_ST_OVER]));
			chk("blank", 32'(v >= `DSR_OVR_COUNT && scans[`DSR_BLINK_BIT]), 32'(rd[`DSR_ST_BLANK]));
			chk("run_slot", 32'h4, 32'(rd[`DSR_ST_RUN:`DSR_ST_SLOT_LO]));
			$display("Test reading %0d done", v);
		end
		// Stop inside the msd gap, then reset while stopped
		@(negedge link.eoc_n);
		bus(1'b1, `DSR_OFS_CTRL, 32'h0);
		bus(1'b0, `DSR_OFS_STATUS, 32'h0);
		chk("run", 32'h0, 32'(rd[`DSR_ST_RUN]));
		chk("eoc_n", 32'h1, 32'(link.eoc_n));
		chk("strobes", 32'h0, 32'({link.msd_strobe, link.third_digit_strobe, link.second_digit_strobe,
			link.lsd_strobe}));
		hresetn <= 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (3) @(posedge hclk);
		chk("first_slot", 32'h1, 32'({link.msd_strobe, link.third_digit_strobe, link.second_digit_strobe,
			link.lsd_strobe}));
		bus(1'b0, `DSR_OFS_CTRL, 32'h0);
		chk("ctrl", `DSR_CTRL_RESET, rd);
		$display("Test stop and reset done");
		end_of_test();
	end
endmodule // digit_scan_reorder_adapter_bench

// [verification/dsr_link_properties.sv]
`timescale 1ns/1ps
`include "dsr_params.svh"
module dsr_link_properties (
	// Clock and reset
	input wire logic       hclk,
	input wire logic       hresetn,
	// Link
	input wire logic [3:0] digit_code,
	input wire logic       msd_strobe,
	input wire logic       second_digit_strobe,
	input wire logic       third_digit_strobe,
	input wire logic       lsd_strobe,
	input wire logic       eoc_n
);
	localparam int GAP = `DSR_GAP_CYC;
	localparam int GAP_HI = `DSR_GAP_CYC + 1;
	localparam int WID = `DSR_STROBE_CYC;
	localparam int SCAN = `DSR_SLOT_CYC * `DSR_SLOTS;
	logic [3:0]  v;
	logic [3:0]  last_q;
	logic [11:0] width_q;
	logic [15:0] per_q;
	logic        any;
	// Native order lsd, third, second, msd runs up the bits
	assign v = {msd_strobe, second_digit_strobe, third_digit_strobe, lsd_strobe};
	assign any = |v;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			width_q <= 12'h000;
		else
			width_q <= any ? width_q + 12'h001 : 12'h000;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			last_q <= 4'h0;
		else if (any)
			last_q <= v;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			per_q <= 16'h0000;
		else
			per_q <= $rose(lsd_strobe) ? 16'h0001 : per_q + 16'h0001;
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_one_slot; $onehot0(v); endproperty
	a_one_slot: assert property (p_one_slot) else $error("Two strobes active");
	property p_first; $rose(any) && last_q == 4'h0 |-> lsd_strobe; endproperty
	a_first: assert property (p_first) else $error("Scan not begun at lsd");
	property p_order; $rose(any) && last_q != 4'h0 |-> v == {last_q[2:0], last_q[3]}; endproperty
	a_order: assert property (p_order) else $error("Scan order wrong");
	property p_width; $fell(any) |-> width_q == WID; endproperty
	a_width: assert property (p_width) else $error("Strobe width wrong");
	property p_gap; $fell(any) |-> ##[GAP:GAP_HI] $rose(any); endproperty
	a_gap: assert property (p_gap) else $error("Slot gap wrong");
	property p_period; $rose(lsd_strobe) && last_q[3] |-> per_q == SCAN; endproperty
	a_period: assert property (p_period) else $error("Scan period wrong");
	property p_hold; any && $past(any) |-> $stable(digit_code); endproperty
	a_hold: assert property (p_hold) else $error("Code moved in slot");
	property p_bcd; any && !msd_strobe |-> digit_code <= 4'h9; endproperty
	a_bcd: assert property (p_bcd) else $error("Code not decimal");
	property p_msd; msd_strobe |-> digit_code[3:2] inside {2'b00, 2'b11}; endproperty
	a_msd: assert property (p_msd) else $error("Msd code out of range");
	property p_eoc; $fell(msd_strobe) |-> ##[0:1] !eoc_n; endproperty
	a_eoc: assert property (p_eoc) else $error("No end of conversion");
	property p_eoc_idle; !eoc_n |-> !any; endproperty
	a_eoc_idle: assert property (p_eoc_idle) else $error("End strobe in slot");
	c_scan: cover property ($rose(lsd_strobe) && last_q[3]);
	c_eoc: cover property ($rose(eoc_n));
	c_msd3: cover property (msd_strobe && digit_code == 4'h3);
	c_blank: cover property (msd_strobe && digit_code == 4'hf);
endmodule // dsr_link_properties
